// ==== core/sdl_pkg.sv ====
// Shared constants and decode helpers for the serial DAC load logic.
// Assumes one system clock domain; all pins arrive asynchronously.

package sdl_pkg;

  // ****************************************************************
  // Word layout
  // ****************************************************************
  localparam int WORD_BITS   = 16;
  localparam int SEG_BITS    = 4;
  localparam int SEG_COUNT   = 15;
  localparam int LADDER_BITS = 12;
  localparam int CNT_BITS    = 5;

  localparam logic [CNT_BITS-1:0]  CNT_FULL   = 5'h10;
  localparam logic [CNT_BITS-1:0]  CNT_RESET  = 5'h00;
  localparam logic [WORD_BITS-1:0] HOLD_RESET = 16'h0000;
  localparam logic [WORD_BITS-1:0] CLEAR_CODE = 16'h0000;

  // ****************************************************************
  // Pin synchroniser
  // ****************************************************************
  localparam int SYNC_STAGES = 2;
  localparam int PIN_COUNT   = 5;
  // Order: chip select, serial clock, data, load strobe, clear
  localparam logic [PIN_COUNT-1:0] PIN_IDLE = 5'h13;
  localparam int PIN_CS  = 4;
  localparam int PIN_SCK = 3;
  localparam int PIN_DIN = 2;
  localparam int PIN_LD  = 1;
  localparam int PIN_CLR = 0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS   = 10;
  localparam int SCLK_MIN_PER_NS = 20;
  // Fastest serial clock period, counted in system clocks
  localparam int SCLK_MIN_CYCLES = SCLK_MIN_PER_NS / CLK_PERIOD_NS;

  // Thermometer decode: bit i set when code exceeds i
  function automatic logic [SEG_COUNT-1:0] therm(
    input logic [SEG_BITS-1:0] k
  );
    logic [SEG_COUNT-1:0] t;
    t = '0;
    for (int i = 0; i < SEG_COUNT; i++) begin
      t[i] = (32'(k) > i);
    end
    return t;
  endfunction

endpackage

// ==== core/sdl_sync.sv ====
// Multi-bit two-stage synchroniser for asynchronous pin inputs.
// Assumes each bit is an independent level; no word coherence.

`timescale 1ns/10ps
`default_nettype none

module sdl_sync #(
  parameter int                 WIDTH     = 1,
  parameter int                 STAGES    = 2,
  parameter logic [WIDTH-1:0]   RESET_VAL = '0
) (
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             ce_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage_q [STAGES];

  if (STAGES < 2) begin : g_chk
    $error("sdl_sync needs at least two stages");
  end

  // ****************************************************************
  // Flop chain; first stage feeds only the second
  // ****************************************************************
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < STAGES; i++) begin
        stage_q[i] <= RESET_VAL;
      end
    end else if (ce_i) begin
      stage_q[0] <= async_i;
      for (int i = 1; i < STAGES; i++) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end

  assign sync_o = stage_q[STAGES-1];

endmodule

`default_nettype wire

// ==== core/sdl_seg_decode.sv ====
// Segmented switch decoder: thermometer top bits, direct ladder bits.
// Purely combinational; the caller registers the results.

`timescale 1ns/10ps
`default_nettype none

module sdl_seg_decode #(
  parameter int SEG_W = 4,
  parameter int LAD_W = 12
) (
  input  wire logic [SEG_W+LAD_W-1:0] code_i,
  output logic      [(1<<SEG_W)-2:0]  segment_switch_o,
  output logic      [LAD_W-1:0]       ladder_switch_o
);

  if (SEG_W < 1 || SEG_W > 6) begin : g_chk
    $error("sdl_seg_decode segment width out of range");
  end

  // ****************************************************************
  // Thermometer: lowest k switches select the reference
  // ****************************************************************
  for (genvar i = 0; i < (1 << SEG_W) - 1; i++) begin : g_seg
    assign segment_switch_o[i] = (32'(code_i[SEG_W+LAD_W-1:LAD_W]) > i);
  end

  // Ladder bit n drives switch n
  assign ladder_switch_o = code_i[LAD_W-1:0];

endmodule

`default_nettype wire

// ==== core/sdl_top.sv ====
// Serial DAC load logic: shift register, holding register, decoder.
// Assumes pins are asynchronous to clk_i and sampled by oversampling.

`timescale 1ns/10ps
`default_nettype none

module sdl_top #(
  parameter int WORD_W = sdl_pkg::WORD_BITS
) (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          ce_i,
  input  wire logic                          chip_sel_n_i,
  input  wire logic                          serial_clk_i,
  input  wire logic                          serial_data_i,
  input  wire logic                          load_strobe_n_i,
  input  wire logic                          async_clear_n_i,
  output logic [sdl_pkg::WORD_BITS-1:0]      dac_code_o,
  output logic [sdl_pkg::SEG_COUNT-1:0]      segment_switch_o,
  output logic [sdl_pkg::LADDER_BITS-1:0]    ladder_switch_o,
  output logic                               word_ready_o
);

  if (WORD_W != sdl_pkg::SEG_BITS + sdl_pkg::LADDER_BITS) begin : g_chk
    $error("sdl_top word width must equal segment plus ladder bits");
  end

  // ****************************************************************
  // Pin synchronisation and edge detection
  // ****************************************************************
  logic [sdl_pkg::PIN_COUNT-1:0] pin_async;
  logic [sdl_pkg::PIN_COUNT-1:0] pin_s;
  logic [sdl_pkg::PIN_COUNT-1:0] pin_prev_q;

  assign pin_async = {chip_sel_n_i, serial_clk_i, serial_data_i,
                      load_strobe_n_i, async_clear_n_i};

  sdl_sync #(
    .WIDTH     (sdl_pkg::PIN_COUNT),
    .STAGES    (sdl_pkg::SYNC_STAGES),
    .RESET_VAL (sdl_pkg::PIN_IDLE)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .async_i (pin_async),
    .sync_o  (pin_s)
  );

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pin_prev_q <= sdl_pkg::PIN_IDLE;
    end else if (ce_i) begin
      pin_prev_q <= pin_s;
    end
  end

  logic cs_low;
  logic cs_rise;
  logic sclk_rise;
  logic din_s;
  logic ld_low;
  logic ld_fall;
  logic clr_low;
  logic clr_fall;

  assign cs_low    = !pin_s[sdl_pkg::PIN_CS];
  assign cs_rise   = pin_s[sdl_pkg::PIN_CS] && !pin_prev_q[sdl_pkg::PIN_CS];
  assign sclk_rise = pin_s[sdl_pkg::PIN_SCK]
                     && !pin_prev_q[sdl_pkg::PIN_SCK];
  assign din_s     = pin_s[sdl_pkg::PIN_DIN];
  assign ld_low    = !pin_s[sdl_pkg::PIN_LD];
  assign ld_fall   = !pin_s[sdl_pkg::PIN_LD] && pin_prev_q[sdl_pkg::PIN_LD];
  assign clr_low   = !pin_s[sdl_pkg::PIN_CLR];
  assign clr_fall  = !pin_s[sdl_pkg::PIN_CLR]
                     && pin_prev_q[sdl_pkg::PIN_CLR];

  // ****************************************************************
  // Input shift register
  // ****************************************************************
  logic [sdl_pkg::WORD_BITS-1:0] shift_q;
  logic [sdl_pkg::CNT_BITS-1:0]  bit_cnt_q;
  logic                          ready_q;
  logic                          shift_en;

  assign shift_en = sclk_rise && cs_low;

  // no reset, so the input register keeps stale bits
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      if (clr_fall) begin
        shift_q <= sdl_pkg::CLEAR_CODE;
      end else if (shift_en) begin
        // first bit walks up to the MSB
        shift_q <= {shift_q[sdl_pkg::WORD_BITS-2:0], din_s};
      end
    end
  end

  // Counter saturates; extra bits still shift through
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      bit_cnt_q <= sdl_pkg::CNT_RESET;
    end else if (ce_i) begin
      if (cs_rise || !cs_low) begin
        bit_cnt_q <= sdl_pkg::CNT_RESET;
      end else if (shift_en && bit_cnt_q != sdl_pkg::CNT_FULL) begin
        bit_cnt_q <= bit_cnt_q + 5'h01;
      end
    end
  end

  // Complete word flag; a new frame withdraws it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ready_q <= 1'b0;
    end else if (ce_i) begin
      if (cs_low) begin
        ready_q <= 1'b0;
      end else if (cs_rise) begin
        ready_q <= (bit_cnt_q == sdl_pkg::CNT_FULL);
      end
    end
  end

  // ****************************************************************
  // Holding register and transfer
  // ****************************************************************
  logic [sdl_pkg::WORD_BITS-1:0] hold_q;
  logic [sdl_pkg::WORD_BITS-1:0] hold_d;
  logic                          cs_xfer;
  logic                          ld_xfer;

  // chip select rise, full word, strobe low
  // no transfer without a framed word
  assign cs_xfer = cs_rise && bit_cnt_q == sdl_pkg::CNT_FULL && ld_low;
  // strobe pulse on a ready word
  // strobes ignored while clear is low
  assign ld_xfer = ld_fall && ready_q && !cs_low;

  always_comb begin
    hold_d = hold_q;
    if (clr_fall) begin
      hold_d = sdl_pkg::CLEAR_CODE;
    end else if (!clr_low && (cs_xfer || ld_xfer)) begin
      hold_d = shift_q;
    end
  end

  // holding moves only on a transfer or a clear falling edge
  // driven by the system clock, not the serial clock
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      hold_q <= sdl_pkg::HOLD_RESET;
    end else if (ce_i) begin
      hold_q <= hold_d;
    end
  end

  // ****************************************************************
  // Switch decode, registered in step with the holding register
  // ****************************************************************
  logic [sdl_pkg::SEG_COUNT-1:0]   seg_d;
  logic [sdl_pkg::LADDER_BITS-1:0] lad_d;

  sdl_seg_decode #(
    .SEG_W (sdl_pkg::SEG_BITS),
    .LAD_W (sdl_pkg::LADDER_BITS)
  ) u_dec (
    .code_i           (hold_d),
    .segment_switch_o (seg_d),
    .ladder_switch_o  (lad_d)
  );

  // code leaves unsigned, no offset or sign handling
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      segment_switch_o <= '0;
      ladder_switch_o  <= '0;
    end else if (ce_i) begin
      segment_switch_o <= seg_d;
      ladder_switch_o  <= lad_d;
    end
  end

  assign dac_code_o   = hold_q;
  assign word_ready_o = ready_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  // Input register has no reset; checks on it wait for known bits
  logic shift_known_q;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      shift_known_q <= 1'b0;
    end else if (ce_i) begin
      if (clr_fall) begin
        shift_known_q <= 1'b1;
      end else if (shift_en && bit_cnt_q == sdl_pkg::CNT_FULL - 5'h01) begin
        shift_known_q <= 1'b1;
      end
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  shift_on_edge_a: assert property (
    ce_i && shift_known_q && shift_en && !clr_fall |=>
      shift_q == {$past(shift_q[14:0]), $past(din_s)})
    else $error("shift register missed a serial bit");

  bit_count_a: assert property (
    ce_i && shift_en && bit_cnt_q < 5'h10 |=>
      bit_cnt_q == $past(bit_cnt_q) + 5'h01)
    else $error("bit count did not advance");

  idle_frame_a: assert property (
    shift_known_q && !cs_low && !clr_fall |=> $stable(shift_q))
    else $error("input register moved with chip select high");

  cs_load_a: assert property (
    ce_i && cs_xfer && !clr_low |=> hold_q == $past(shift_q))
    else $error("chip select rise did not load holding");

  cs_keep_a: assert property (
    ce_i && cs_rise && !ld_low && !clr_fall |=> $stable(hold_q))
    else $error("holding changed with strobe high");

  strobe_load_a: assert property (
    ce_i && ld_fall && ready_q && !cs_low && !clr_low |=>
      hold_q == $past(shift_q) && word_ready_o)
    else $error("strobe did not transfer ready word");

  preload_safe_a: assert property (
    cs_low && !clr_fall |=> $stable(hold_q))
    else $error("holding changed during shifting");

  ready_set_a: assert property (
    ce_i && cs_rise |=>
      word_ready_o == ($past(bit_cnt_q) == sdl_pkg::CNT_FULL))
    else $error("word ready flag wrong after frame");

  short_frame_a: assert property (
    ce_i && cs_rise && bit_cnt_q != sdl_pkg::CNT_FULL && !clr_fall |=>
      $stable(hold_q))
    else $error("short frame changed holding");

  strobe_level_a: assert property (
    ld_low && !ld_fall && !cs_rise && !clr_fall |=> $stable(hold_q))
    else $error("held strobe level reloaded holding");

  freeze_hold_a: assert property (
    !ce_i |=> $stable(hold_q) && $stable(ready_q) && $stable(bit_cnt_q))
    else $error("state moved with clock enable low");

  seg_therm_a: assert property (
    segment_switch_o == sdl_pkg::therm(dac_code_o[15:12]))
    else $error("segment switches disagree with code");

  ladder_map_a: assert property (
    ladder_switch_o == dac_code_o[11:0])
    else $error("ladder switches disagree with code");

  clear_zero_a: assert property (
    ce_i && clr_fall |=> hold_q == 16'h0000 && shift_q == 16'h0000)
    else $error("clear did not zero both registers");

  clear_block_a: assert property (
    clr_low && !clr_fall |=> $stable(hold_q))
    else $error("holding loaded while clear low");

  cs_load_c:     cover property (ce_i && cs_xfer && !clr_low);
  strobe_load_c: cover property (ce_i && ld_xfer && !clr_low);
  clear_c:       cover property (ce_i && clr_fall);
  long_frame_c:  cover property (cs_low && bit_cnt_q == 5'h10 && shift_en);

endmodule

`default_nettype wire

// ==== testbench/sdl_host_model.sv ====
// Host serial master model for the serial DAC load logic.
// Assumes the bench calls its tasks; clk_i only paces pin changes.

`timescale 1ns/10ps
`default_nettype none

module sdl_host_model (
  input  wire logic clk_i,
  output logic      chip_sel_n_o,
  output logic      serial_clk_o,
  output logic      serial_data_o,
  output logic      load_strobe_n_o,
  output logic      async_clear_n_o
);
  localparam realtime HALF_NS = 62.5;

  initial begin
    chip_sel_n_o    = 1'b1;
    serial_clk_o    = 1'b0;
    serial_data_o   = 1'b0;
    load_strobe_n_o = 1'b1;
    async_clear_n_o = 1'b1;
  end

  // ****************************************************************
  // Frame control
  // ****************************************************************
  task automatic cs_low(input logic ld_lvl);
    @(negedge clk_i);
    chip_sel_n_o = 1'b0;
    // Strobe moves only with chip select low, so it never loads early
    repeat (4) @(negedge clk_i);
    load_strobe_n_o = ld_lvl;
  endtask

  // data set at clock fall, MSB first
  task automatic nib(input logic [3:0] b);
    for (int i = 3; i >= 0; i--) begin
      serial_data_o = b[i];
      #(HALF_NS) serial_clk_o = 1'b1;
      #(HALF_NS) serial_clk_o = 1'b0;
    end
  endtask

  task automatic word(input logic [15:0] w);
    nib(w[15:12]);
    nib(w[11:8]);
    nib(w[7:4]);
    nib(w[3:0]);
  endtask

  task automatic cs_high();
    #(HALF_NS);
    @(negedge clk_i);
    chip_sel_n_o = 1'b1;
    // Released data line must not keep its last value
    serial_data_o = ~serial_data_o;
    repeat (6) @(negedge clk_i);
    load_strobe_n_o = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask

  // ****************************************************************
  // Deselected activity, strobe, clear
  // ****************************************************************
  task automatic noise(input int n);
    for (int i = 0; i < n; i++) begin
      serial_data_o = ~serial_data_o;
      #(HALF_NS) serial_clk_o = 1'b1;
      #(HALF_NS) serial_clk_o = 1'b0;
    end
  endtask

  task automatic strobe();
    @(negedge clk_i);
    load_strobe_n_o = 1'b0;
    repeat (6) @(negedge clk_i);
    load_strobe_n_o = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask

  task automatic set_clear(input logic lvl);
    @(negedge clk_i);
    async_clear_n_o = lvl;
    repeat (4) @(negedge clk_i);
  endtask
endmodule

`default_nettype wire

// ==== testbench/test_serial_dac_load_logic.sv ====
// Self-checking bench for the serial DAC load logic top.
// Assumes sdl_host_model drives every pin; clock enable high except in t_freeze.

`timescale 1ns/10ps
`default_nettype none

module test_serial_dac_load_logic;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce    = 1'b1;
  logic        cs_n;
  logic        sclk;
  logic        din;
  logic        ld_n;
  logic        clr_n;
  logic [15:0] code;
  logic [14:0] seg;
  logic [11:0] lad;
  logic        ready;
  int          mismatches  = 0;
  int          check_count = 0;
  int          cycles      = 0;

  initial forever #5 clk_i = ~clk_i;

  // Run is about 3500 cycles; ceiling leaves wide margin
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      complete_run();
    end
  end

  sdl_host_model u_host (
    .clk_i           (clk_i),
    .chip_sel_n_o    (cs_n),
    .serial_clk_o    (sclk),
    .serial_data_o   (din),
    .load_strobe_n_o (ld_n),
    .async_clear_n_o (clr_n)
  );

  sdl_top dut (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .ce_i             (ce),
    .chip_sel_n_i     (cs_n),
    .serial_clk_i     (sclk),
    .serial_data_i    (din),
    .load_strobe_n_i  (ld_n),
    .async_clear_n_i  (clr_n),
    .dac_code_o       (code),
    .segment_switch_o (seg),
    .ladder_switch_o  (lad),
    .word_ready_o     (ready)
  );

  // ****************************************************************
  // Checking helpers
  // ****************************************************************
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle();
    repeat (6) @(negedge clk_i);
  endtask

  task automatic check_out(input logic [15:0] w);
    check(code, w);
    check(lad, w[11:0]);
    check(seg, 15'h7FFF >> (15 - w[15:12]));
  endtask

  task automatic send(input logic [15:0] w, input logic ld_lvl);
    u_host.cs_low(ld_lvl);
    u_host.word(w);
    u_host.cs_high();
    settle();
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    check_out(16'h0000);
    check(ready, 1'b0);
  endtask

  task automatic t_direct();
    logic [15:0] codes [0:4] = '{16'hFFFF, 16'h8000, 16'h0001,
                                 16'h0000, 16'hA5C3};
    for (int i = 0; i < 5; i++) begin
      send(codes[i], 1'b0);
      check_out(codes[i]);
      check(ready, 1'b1);
    end
  endtask

  task automatic t_preload();
    send(16'h1234, 1'b1);
    check_out(16'hA5C3);
    check(ready, 1'b1);
    u_host.strobe();
    settle();
    check_out(16'h1234);
  endtask

  task automatic t_idle();
    send(16'h4321, 1'b1);
    u_host.noise(20);
    settle();
    check_out(16'h1234);
    u_host.strobe();
    settle();
    check_out(16'h4321);
  endtask

  task automatic t_length();
    u_host.cs_low(1'b0);
    u_host.nib(4'hF);
    u_host.word(16'h0F0F);
    u_host.cs_high();
    settle();
    check_out(16'h0F0F);
    u_host.cs_low(1'b0);
    u_host.nib(4'h3);
    u_host.nib(4'hC);
    u_host.cs_high();
    settle();
    check_out(16'h0F0F);
    check(ready, 1'b0);
  endtask

  task automatic t_clear();
    send(16'h9999, 1'b1);
    u_host.set_clear(1'b0);
    settle();
    check_out(16'h0000);
    send(16'h6C6C, 1'b1);
    check(ready, 1'b1);
    u_host.strobe();
    settle();
    check_out(16'h0000);
    u_host.set_clear(1'b1);
    u_host.strobe();
    settle();
    check_out(16'h6C6C);
  endtask

  task automatic t_rerst();
    send(16'hBEEF, 1'b0);
    check_out(16'hBEEF);
    @(negedge clk_i);
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    settle();
    check_out(16'h0000);
    check(ready, 1'b0);
  endtask

  task automatic t_freeze();
    ce = 1'b0;
    send(16'h5A5A, 1'b0);
    check_out(16'h0000);
    check(ready, 1'b0);
    ce = 1'b1;
    send(16'h5A5A, 1'b0);
    check_out(16'h5A5A);
  endtask

  task automatic complete_run();
    if (mismatches == 0 && check_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (3) @(negedge clk_i);
    t_reset();
    t_direct();
    t_preload();
    t_idle();
    t_length();
    t_clear();
    t_rerst();
    t_freeze();
    complete_run();
  end
endmodule

`default_nettype wire
